// ---- rtl/mrc_reset_ctrl.sv ----
// mrc_reset_ctrl: reset source gathering, stabilization delay and pin pulldown
`timescale 1ns/1ps
module mrc_reset_ctrl import mrc_pkg::*; #(
  parameter int POR_DELAY = MRC_POR_DELAY_CYC
) (
  // clock and power-on reset (rstn is the power-on detector)
  input wire logic clk,
  input wire logic rstn,
  // oscillator running indication (asynchronous)
  input wire logic osc_active,
  // reset pin, open drain
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // internal reset causes
  input wire logic wdog_timeout,
  input wire logic low_volt,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  // software access to control bits
  input wire logic por_flag_wr,
  input wire logic por_flag_wdata,
  input wire logic wdog_en_set,
  // outputs toward cpu and peripherals
  output logic sys_rst_n,
  output logic load_vector,
  output logic [15:0] reset_vector,
  output logic por_flag,
  output logic watchdog_enable_bit
);
  localparam int CW = $clog2(POR_DELAY + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY - 1);
  localparam logic [2:0] PD_LAST = 3'(MRC_PD_HOLD_CYC - 1);

  mrc_state_t state_r, state_nxt;
  logic [CW-1:0] por_cnt_r;
  logic [2:0] pd_cnt_r;
  logic pd_on_r;
  logic sys_rst_n_r;
  logic load_vec_r;
  logic por_flag_r;
  logic wdog_en_r;
  logic illegal_r;
  logic pin_s;
  logic osc_s;
  logic [1:0] pd_tail_r;

  // pin and oscillator pass two flops before any logic
  mrc_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .d(rst_pin_i),
    .q(pin_s)
  );
  mrc_sync #(.RST_VAL(1'b0)) u_osc_sync (
    .clk(clk),
    .rstn(rstn),
    .d(osc_active),
    .q(osc_s)
  );

  // decode of the causes; pin low seen while we drive it is our own pulldown
  wire in_rom = (fetch_addr >= MRC_ROM_LO) && (fetch_addr <= MRC_ROM_HI);
  wire in_vec = (fetch_addr >= MRC_VEC_LO) && (fetch_addr <= MRC_VEC_HI);
  wire in_ram = (fetch_addr >= MRC_RAM_LO) && (fetch_addr <= MRC_RAM_HI);
  wire illegal_fetch = fetch_valid && !(in_rom || in_vec || in_ram);
  // a real external low inside the two-cycle tail is only seen once it ends
  wire own_low = pd_on_r || (pd_tail_r != 2'h0);
  wire ext_low = !pin_s && !own_low;
  wire int_cause = (wdog_timeout && wdog_en_r) || low_volt || illegal_r;
  wire pd_done = (pd_cnt_r >= PD_LAST);
  wire any_cause = ext_low || int_cause || pd_on_r;
  wire por_done = osc_s && (por_cnt_r == POR_LAST);

  // illegal fetch captured for one cycle so it acts as a clean cause
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= illegal_fetch;
    end
  end

  // stabilization counter only advances while the oscillator runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_r <= '0;
    end else if (state_r == MRC_ST_POR && osc_s && !por_done) begin
      por_cnt_r <= por_cnt_r + CW'(1);
    end
  end

  // sequencer: power-up delay, hold while causes active, run
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MRC_ST_POR: begin
        if (por_done) begin
          state_nxt = any_cause ? MRC_ST_HOLD : MRC_ST_RUN;
        end
      end
      MRC_ST_HOLD: begin
        if (!any_cause) begin
          state_nxt = MRC_ST_RUN;
        end
      end
      MRC_ST_RUN: begin
        if (any_cause) begin
          state_nxt = MRC_ST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= MRC_ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pulldown: starts only for internal causes with pin not held low outside;
  // the 4-cycle hold sits inside the 3..4 window and covers sync latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_on_r <= 1'b0;
      pd_cnt_r <= '0;
    end else if (!pd_on_r) begin
      if (int_cause && pin_s && state_r != MRC_ST_POR) begin
        pd_on_r <= 1'b1;
        pd_cnt_r <= '0;
      end
    end else if (!pd_done) begin
      pd_cnt_r <= pd_cnt_r + 3'd1;
    end else if (!int_cause) begin
      pd_on_r <= 1'b0;
    end
  end

  // the synchronised pin stays low two edges after our pulldown lets go;
  // this tail keeps that echo from reading as an external reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_tail_r <= 2'h0;
    end else begin
      pd_tail_r <= {pd_tail_r[0], pd_on_r};
    end
  end

  // internal reset: asserted at once with power-on, released on the clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_rst_n_r <= 1'b0;
      load_vec_r <= 1'b0;
    end else begin
      sys_rst_n_r <= (state_nxt == MRC_ST_RUN) && !any_cause;
      load_vec_r <= !sys_rst_n_r && (state_nxt == MRC_ST_RUN) && !any_cause;
    end
  end

  // power-on flag: set by power-up, software may only clear it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_flag_r <= MRC_POR_FLAG_RST;
    end else if (por_flag_wr && !por_flag_wdata) begin
      por_flag_r <= 1'b0;
    end
  end

  // watchdog enable is sticky; cleared by power-on or external reset only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdog_en_r <= MRC_WDOG_EN_RST;
    end else if (ext_low) begin
      wdog_en_r <= 1'b0;
    end else if (wdog_en_set && sys_rst_n_r) begin
      wdog_en_r <= 1'b1;
    end
  end

  // outputs straight from flops, except reset_vector and rst_pin_o, which are constants
  assign sys_rst_n = sys_rst_n_r;
  assign load_vector = load_vec_r;
  assign reset_vector = MRC_RESET_VEC;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = pd_on_r;
  assign por_flag = por_flag_r;
  assign watchdog_enable_bit = wdog_en_r;

  // pulldown lasts at least the minimum once started
  property p_pd_min;
    @(posedge clk) disable iff (!rstn) $rose(pd_on_r) |-> pd_on_r [*3];
  endproperty
  a_pd_min: assert property (p_pd_min) else $error("pulldown too short");

  property p_pd_cause;
    @(posedge clk) disable iff (!rstn) $rose(pd_on_r) |-> $past(int_cause);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("pulldown without cause");

  property p_pd_ext;
    @(posedge clk) disable iff (!rstn) $rose(pd_on_r) |-> $past(pin_s);
  endproperty
  a_pd_ext: assert property (p_pd_ext) else $error("pulldown against external low");

  property p_pd_por;
    @(posedge clk) disable iff (!rstn) (state_r == MRC_ST_POR) |-> !pd_on_r;
  endproperty
  a_pd_por: assert property (p_pd_por) else $error("pulldown during power-up");

  property p_por_hold;
    @(posedge clk) disable iff (!rstn) (state_r == MRC_ST_POR) && !por_done |=> !sys_rst_n_r;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("released during delay");

  property p_pin_hold;
    @(posedge clk) disable iff (!rstn) ext_low |=> !sys_rst_n_r;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("released while pin low");

  property p_cause_hold;
    @(posedge clk) disable iff (!rstn) int_cause |=> !sys_rst_n_r;
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("released with cause");

  property p_flag_noset;
    @(posedge clk) disable iff (!rstn) !por_flag_r |=> !por_flag_r;
  endproperty
  a_flag_noset: assert property (p_flag_noset) else $error("power flag set by sw");

  property p_wdog_sticky;
    @(posedge clk) disable iff (!rstn) (wdog_en_r && !ext_low) |=> wdog_en_r;
  endproperty
  a_wdog_sticky: assert property (p_wdog_sticky) else $error("watchdog disabled");

  property p_illegal;
    @(posedge clk) disable iff (!rstn) illegal_fetch |=> ##1 !sys_rst_n_r;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal fetch ignored");

  // counter must not run before the oscillator is seen
  property p_osc_wait;
    @(posedge clk) disable iff (!rstn) ((state_r == MRC_ST_POR) && !osc_s) |=> $stable(por_cnt_r);
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("delay counted without osc");

  // pulldown echo on the pin must not clear the watchdog enable
  property p_wdog_echo;
    @(posedge clk) disable iff (!rstn)
      ($fell(pd_on_r) && wdog_en_r) |-> wdog_en_r ##1 wdog_en_r ##1 wdog_en_r;
  endproperty
  a_wdog_echo: assert property (p_wdog_echo) else $error("echo cleared watchdog");

  // vector load is a single pulse that marks the release
  property p_load_pulse;
    @(posedge clk) disable iff (!rstn) load_vec_r |=> !load_vec_r;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("vector load too long");

  property p_load_rel;
    @(posedge clk) disable iff (!rstn) $rose(sys_rst_n_r) |-> load_vec_r;
  endproperty
  a_load_rel: assert property (p_load_rel) else $error("no vector load at release");

  property p_rel_clean;
    @(posedge clk) disable iff (!rstn) $rose(sys_rst_n_r) |-> !$past(any_cause);
  endproperty
  a_rel_clean: assert property (p_rel_clean) else $error("release with cause left");

  // pulldown starts for an internal cause and stops once done and cause gone
  property p_pd_start;
    @(posedge clk) disable iff (!rstn)
      (int_cause && pin_s && !pd_on_r && state_r != MRC_ST_POR) |=> pd_on_r;
  endproperty
  a_pd_start: assert property (p_pd_start) else $error("pulldown not started");

  property p_pd_end;
    @(posedge clk) disable iff (!rstn) (pd_on_r && pd_done && !int_cause) |=> !pd_on_r;
  endproperty
  a_pd_end: assert property (p_pd_end) else $error("pulldown too long");

  property p_no_pd_ext;
    @(posedge clk) disable iff (!rstn) (!pin_s && !pd_on_r) |=> !pd_on_r;
  endproperty
  a_no_pd_ext: assert property (p_no_pd_ext) else $error("pulldown on low pin");

  c_release: cover property (@(posedge clk) disable iff (!rstn) $rose(sys_rst_n_r));
  c_pulldown: cover property (@(posedge clk) disable iff (!rstn) $fell(pd_on_r));
  c_ext: cover property (@(posedge clk) disable iff (!rstn) sys_rst_n_r ##1 ext_low);
  c_por_hold: cover property (@(posedge clk) disable iff (!rstn)
    (state_r == MRC_ST_POR) ##1 (state_r == MRC_ST_HOLD));
  c_illegal: cover property (@(posedge clk) disable iff (!rstn) illegal_r ##1 pd_on_r);
endmodule // mrc_reset_ctrl

// ---- rtl/mrc_pkg.sv ----
// mrc_pkg: constants shared by the reset controller files
package mrc_pkg;
  // power-up stabilization delay in bus cycles
  localparam int MRC_POR_DELAY_CYC = 4064;
  // pulldown pulse: 3 to 4 bus cycles, we hold 4
  localparam int MRC_PD_MIN_CYC = 3;
  localparam int MRC_PD_HOLD_CYC = 4;
  // external pin low time, printed as 1.5 bus cycles (in tenths)
  localparam int MRC_PIN_LOW_TENTHS = 15;
  // clock period in ns and the derived least pin-low count
  localparam int MRC_CLK_NS = 8;
  localparam int MRC_BUS_NS = 8;
  localparam int MRC_PIN_LOW_CYC = (MRC_PIN_LOW_TENTHS * MRC_BUS_NS + 10 * MRC_CLK_NS - 1)
                                   / (10 * MRC_CLK_NS);
  // legal opcode fetch windows
  localparam logic [15:0] MRC_ROM_LO = 16'h0E00;
  localparam logic [15:0] MRC_ROM_HI = 16'h1DFF;
  localparam logic [15:0] MRC_VEC_LO = 16'h1FF0;
  localparam logic [15:0] MRC_VEC_HI = 16'h1FFF;
  localparam logic [15:0] MRC_RAM_LO = 16'h0020;
  localparam logic [15:0] MRC_RAM_HI = 16'h011F;
  // reset vector location
  localparam logic [15:0] MRC_RESET_VEC = 16'h1FFE;
  // reset values of control bits
  localparam logic MRC_WDOG_EN_RST = 1'b0;
  localparam logic MRC_POR_FLAG_RST = 1'b1;
  // sequencer states
  typedef enum logic [1:0] {MRC_ST_POR, MRC_ST_HOLD, MRC_ST_RUN} mrc_state_t;
endpackage

// ---- rtl/mrc_sync.sv ----
// mrc_sync: two flip-flop level synchroniser
`timescale 1ns/1ps
module mrc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and synchronised out
  input wire logic d,
  output logic q
);
  logic meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // mrc_sync

// ---- tb/mrc_pin_model.sv ----
// mrc_pin_model: external reset circuitry with a pull-up on the reset pin
`timescale 1ns/1ps
module mrc_pin_model (
  // clock and request to pull the pin low
  input wire logic clk,
  input wire logic req_low,
  // device open-drain drive
  input wire logic oe,
  input wire logic o,
  // resolved pin level
  output logic pin
);
  logic [1:0] hold_r;
  logic drv;
  initial hold_r = 2'h0;
  // a short request is stretched, never shorter than two bus cycles
  always @(posedge clk) begin
    hold_r <= req_low ? 2'h2 : ((hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0);
  end
  assign drv = req_low | (hold_r != 2'h0);
  // pull-up: a released pin floats high, any drive wins
  assign pin = (drv || (oe && !o)) ? 1'b0 : 1'b1;
endmodule // mrc_pin_model

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the reset controller
`timescale 1ns/1ps
module tb_top;
  import mrc_pkg::*;
  localparam int PD = 16;
  logic clk, rstn, osc, ext_req, wdt, lv, fv, pwr, pwd, wse, pin;
  logic po, poe, srn, ldv, pf, wen;
  logic [15:0] fa, rv;
  int errors, samples_checked, n;
  logic seen_oe, v;
  mrc_reset_ctrl #(.POR_DELAY(PD)) dut (.clk(clk), .rstn(rstn), .osc_active(osc),
    .rst_pin_i(pin), .rst_pin_o(po), .rst_pin_oe(poe), .wdog_timeout(wdt), .low_volt(lv),
    .fetch_valid(fv), .fetch_addr(fa), .por_flag_wr(pwr), .por_flag_wdata(pwd),
    .wdog_en_set(wse), .sys_rst_n(srn), .load_vector(ldv), .reset_vector(rv),
    .por_flag(pf), .watchdog_enable_bit(wen));
  mrc_pin_model pm (.clk(clk), .req_low(ext_req), .oe(poe), .o(po), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(int k = 1);
    repeat (k) begin @(posedge clk); #1; seen_oe |= (poe === 1'b1); end
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // wait for release under a bound, noting the vector load pulse
  task automatic wait_rel(int lim, output int c, output logic lp);
    lp = 1'b0;
    c = 0;
    while (srn !== 1'b1 && c < lim) begin tick(); c++; lp |= (ldv === 1'b1); end
    if (srn !== 1'b1) begin errors++; tally_and_finish(); end
    repeat (2) begin tick(); lp |= (ldv === 1'b1); end
  endtask
  // internal cause k: 0 low voltage, 1 watchdog, 2 fetch at ad for one cycle; the others held h cycles
  task automatic int_rst(int k, int h, logic [15:0] ad, int lo, int hi);
    int c, m;
    logic p;
    c = 0;
    lv = (k == 0);
    wdt = (k == 1);
    fv = (k == 2);
    fa = ad;
    repeat (h) begin tick(); fv = 1'b0; if (poe === 1'b1) c++; end
    lv = 1'b0;
    wdt = 1'b0;
    for (m = 0; m < 3 && c == 0; m++) begin tick(); if (poe === 1'b1) c++; end
    chk("rst_during_pd", srn, 1'b0);
    chk("pd_drive_low", po, 1'b0);
    while (poe === 1'b1 && m < 30) begin tick(); if (poe === 1'b1) c++; m++; end
    chk("pd_len_ok", (c >= lo) && (c <= hi), 1'b1);
    wait_rel(10, m, p);
    chk("load_vector", p, 1'b1);
    chk("reset_vector", rv, MRC_RESET_VEC);
  endtask
  task automatic t_por_pin_low();
    rstn = 1'b0;
    ext_req = 1'b1;
    seen_oe = 1'b0;
    tick(5);
    rstn = 1'b1;
    osc = 1'b1;
    tick(PD + 10);
    chk("rst_pin_held", srn, 1'b0);
    ext_req = 1'b0;
    wait_rel(8, n, v);
    chk("load_vector_por", v, 1'b1);
    chk("por_no_pd", seen_oe, 1'b0);
    chk("por_flag", pf, MRC_POR_FLAG_RST);
    chk("wdog_en_rst", wen, MRC_WDOG_EN_RST);
  endtask
  task automatic t_flag_and_repower();
    pwr = 1'b1;
    pwd = 1'b1;
    tick();
    pwr = 1'b0;
    tick();
    chk("flag_no_set", pf, 1'b1);
    pwr = 1'b1;
    pwd = 1'b0;
    tick();
    pwr = 1'b0;
    tick();
    chk("flag_cleared", pf, 1'b0);
    rstn = 1'b0;
    tick();
    rstn = 1'b1;
    wait_rel(PD + 10, n, v);
    chk("por_delay_ok", n, PD + 2);
    chk("flag_set_again", pf, 1'b1);
  endtask
  task automatic t_ext();
    seen_oe = 1'b0;
    ext_req = 1'b1;
    tick(4);
    chk("ext_rst", srn, 1'b0);
    lv = 1'b1;
    tick();
    lv = 1'b0;
    tick();
    ext_req = 1'b0;
    wait_rel(10, n, v);
    chk("no_pd_on_ext", seen_oe, 1'b0);
    chk("wdog_en_ext_clr", wen, 1'b0);
  endtask
  initial begin
    {osc, ext_req, wdt, lv, fv, pwr, pwd, wse} = 8'h00;
    rstn = 1'b0;
    fa = 16'h0000;
    errors = 0;
    samples_checked = 0;
    t_por_pin_low();
    t_flag_and_repower();
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    tick(4);
    chk("wdog_off_no_rst", srn, 1'b1);
    wse = 1'b1;
    tick();
    wse = 1'b0;
    int_rst(1, 1, 16'h0000, 3, 4);
    int_rst(0, 1, 16'h0000, 3, 4);
    int_rst(0, 8, 16'h0000, 8, 8);
    int_rst(2, 1, 16'h1E00, 3, 4);
    int_rst(2, 1, 16'h001F, 3, 4);
    chk("wdog_en_sticks", wen, 1'b1);
    for (int i = 0; i < 5; i++) begin
      fv = 1'b1;
      fa = (i == 0) ? 16'h0E00 : (i == 1) ? 16'h1DFF : (i == 2) ? 16'h0020 : 16'h011F;
      if (i == 4) fa = 16'h1FF0;
      tick();
      fv = 1'b0;
      tick(4);
      chk("legal_fetch", srn, 1'b1);
    end
    t_ext();
    tally_and_finish();
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // tb_top
